// ===== mlfc_top.sv
// Purpose: lock fault configuration register bank with lock fault gating
// Assumes: detector inputs come from logic on the same clock
// Notes: unmapped addresses answer slverr and read as zero
// Operation
// RQ1: config word at index 92h, resets zero
// RQ2: bit 30 enables abnormal speed detector
// RQ3: bit 29 enables abnormal back-emf detector
// RQ4: bit 28 enables no-motor detector
// RQ5: bits 27-25 pick overspeed threshold code
// RQ6: bits 24-22 pick back-emf threshold code
// RQ7: bits 21-19 pick no-motor current threshold
// RQ8: disabled detector never raises a lock fault
`timescale 1ns/10ps
module mlfc_top (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [mlfc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [mlfc_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [mlfc_pkg::STRB_W-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [mlfc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [mlfc_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic overspeed_detect,
	input wire logic backemf_detect,
	input wire logic nomotor_detect,
	output logic overspeed_lock_enable,
	output logic backemf_lock_enable,
	output logic nomotor_lock_enable,
	output logic [mlfc_pkg::THR_W-1:0] overspeed_threshold_code,
	output logic [mlfc_pkg::THR_W-1:0] backemf_threshold_code,
	output logic [mlfc_pkg::THR_W-1:0] nomotor_current_threshold_code,
	output logic overspeed_lock_fault,
	output logic backemf_lock_fault,
	output logic nomotor_lock_fault,
	output logic irq
);
	localparam logic [mlfc_pkg::ADDR_W-1:0] CFG_ADDR = mlfc_pkg::idx_to_addr(mlfc_pkg::CFG_IDX);
	localparam logic [mlfc_pkg::ADDR_W-1:0] STAT_ADDR =
		mlfc_pkg::idx_to_addr(mlfc_pkg::STAT_IDX);
	localparam logic [mlfc_pkg::ADDR_W-1:0] MASK_ADDR =
		mlfc_pkg::idx_to_addr(mlfc_pkg::MASK_IDX);

	mlfc_reg_if rif (); // bus to bank carrier

	logic [31:0] cfg_q, cfg_d; // lock fault configuration word
	logic [mlfc_pkg::EV_W-1:0] stat_q, stat_d; // sticky lock events
	logic [mlfc_pkg::EV_W-1:0] mask_q, mask_d; // interrupt enables
	logic [mlfc_pkg::EV_W-1:0] fault_q, fault_d; // gated lock faults
	logic irq_q, irq_d;
	logic [mlfc_pkg::EV_W-1:0] en_vec; // detector enables
	logic [mlfc_pkg::EV_W-1:0] det_vec; // raw detector levels
	logic [mlfc_pkg::EV_W-1:0] clr_vec; // write-one-to-clear bits
	logic [31:0] wmask; // bit mask from byte strobes
	logic cfg_wr, stat_wr, mask_wr;

	// expand byte strobes to a bit mask
	function automatic logic [31:0] strb_mask(input logic [mlfc_pkg::STRB_W-1:0] strb);
		logic [31:0] m;
		m = '0;
		for (int i = 0; i < mlfc_pkg::STRB_W; i++) begin
			m[i*8 +: 8] = {8{strb[i]}};
		end
		return m;
	endfunction : strb_mask

	// address hit, used by both decode paths
	function automatic logic hit(input logic [mlfc_pkg::ADDR_W-1:0] a,
		input logic [mlfc_pkg::ADDR_W-1:0] r);
		return a == r;
	endfunction : hit

	// bus slave
	mlfc_axil_slave u_slave (
		.clock(clock),
		.arst_n(arst_n),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.rif(rif.bus)
	);

	// write decode
	assign wmask = strb_mask(rif.wr_strb);
	assign cfg_wr = rif.wr_en && hit(rif.wr_addr, CFG_ADDR); // RQ1
	assign stat_wr = rif.wr_en && hit(rif.wr_addr, STAT_ADDR);
	assign mask_wr = rif.wr_en && hit(rif.wr_addr, MASK_ADDR);
	assign rif.wr_err = !(hit(rif.wr_addr, CFG_ADDR) || hit(rif.wr_addr, STAT_ADDR) ||
		hit(rif.wr_addr, MASK_ADDR));
	assign clr_vec = stat_wr ? rif.wr_data[mlfc_pkg::EV_W-1:0] &
		wmask[mlfc_pkg::EV_W-1:0] : '0;

	// read mux; narrow registers sit in the low bits
	always_comb begin
		rif.rd_data = '0;
		rif.rd_err = 1'b0;
		if (hit(rif.rd_addr, CFG_ADDR)) begin
			rif.rd_data = cfg_q;
		end else if (hit(rif.rd_addr, STAT_ADDR)) begin
			rif.rd_data[mlfc_pkg::EV_W-1:0] = stat_q;
		end else if (hit(rif.rd_addr, MASK_ADDR)) begin
			rif.rd_data[mlfc_pkg::EV_W-1:0] = mask_q;
		end else begin
			rif.rd_err = 1'b1; // unmapped
		end
	end

	// field extraction straight from the stored word
	assign overspeed_lock_enable = cfg_q[mlfc_pkg::OVS_EN_BIT]; // RQ2
	assign backemf_lock_enable = cfg_q[mlfc_pkg::BEMF_EN_BIT]; // RQ3
	assign nomotor_lock_enable = cfg_q[mlfc_pkg::NOM_EN_BIT]; // RQ4
	// code 0..7 = 130%..200% of max speed
	assign overspeed_threshold_code = cfg_q[mlfc_pkg::OVS_THR_LSB +: mlfc_pkg::THR_W]; // RQ5
	// code 0..7 = 10%..80% of expected back-emf
	assign backemf_threshold_code = cfg_q[mlfc_pkg::BEMF_THR_LSB +: mlfc_pkg::THR_W]; // RQ6
	// code 0..7 = 0.05 A .. 1.0 A, non-linear steps decoded downstream
	assign nomotor_current_threshold_code =
		cfg_q[mlfc_pkg::NOM_THR_LSB +: mlfc_pkg::THR_W]; // RQ7

	assign en_vec = {nomotor_lock_enable, backemf_lock_enable, overspeed_lock_enable};
	assign det_vec = {nomotor_detect, backemf_detect, overspeed_detect};

	// next values of the bank
	always_comb begin
		cfg_d = cfg_q;
		mask_d = mask_q;
		// all 32 bits stored, including fields with no local effect
		if (cfg_wr) begin
			cfg_d = (cfg_q & ~wmask) | (rif.wr_data & wmask); // RQ1
		end
		if (mask_wr) begin
			mask_d = (mask_q & ~wmask[mlfc_pkg::EV_W-1:0]) |
				(rif.wr_data[mlfc_pkg::EV_W-1:0] & wmask[mlfc_pkg::EV_W-1:0]);
		end
		// gating by enable; threshold has no say when disabled
		fault_d = det_vec & en_vec; // RQ8
		// set beats clear so an event in the clearing cycle survives
		stat_d = (stat_q & ~clr_vec) | fault_d; // RQ8
		irq_d = |(stat_d & mask_d);
	end

	// bank registers
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			cfg_q <= mlfc_pkg::CFG_RST; // RQ1
			stat_q <= mlfc_pkg::EV_RST;
			mask_q <= mlfc_pkg::EV_RST;
			fault_q <= mlfc_pkg::EV_RST;
			irq_q <= 1'b0;
		end else begin
			cfg_q <= cfg_d;
			stat_q <= stat_d;
			mask_q <= mask_d;
			fault_q <= fault_d;
			irq_q <= irq_d;
		end
	end

	assign overspeed_lock_fault = fault_q[mlfc_pkg::EV_OVS];
	assign backemf_lock_fault = fault_q[mlfc_pkg::EV_BEMF];
	assign nomotor_lock_fault = fault_q[mlfc_pkg::EV_NOM];
	assign irq = irq_q;

	// checks
	property p_cfg_reset;
		@(posedge clock) !arst_n |-> cfg_q == mlfc_pkg::CFG_RST;
	endproperty
	a_cfg_reset: assert property (p_cfg_reset) else $error("config not zero in reset"); // RQ1

	property p_cfg_write;
		@(posedge clock) disable iff (!arst_n)
		rif.wr_en && rif.wr_addr == CFG_ADDR && rif.wr_strb == mlfc_pkg::STRB_ALL
		##1 !rif.wr_en [*2] |-> cfg_q == $past(rif.wr_data, 2);
	endproperty
	a_cfg_write: assert property (p_cfg_write) else $error("config write lost"); // RQ1

	property p_ovs_en;
		@(posedge clock) disable iff (!arst_n)
		cfg_wr && wmask[mlfc_pkg::OVS_EN_BIT]
		|=> overspeed_lock_enable == $past(rif.wr_data[mlfc_pkg::OVS_EN_BIT]);
	endproperty
	a_ovs_en: assert property (p_ovs_en) else $error("overspeed enable wrong"); // RQ2

	property p_bemf_en;
		@(posedge clock) disable iff (!arst_n)
		cfg_wr && wmask[mlfc_pkg::BEMF_EN_BIT]
		|=> backemf_lock_enable == $past(rif.wr_data[mlfc_pkg::BEMF_EN_BIT]);
	endproperty
	a_bemf_en: assert property (p_bemf_en) else $error("back-emf enable wrong"); // RQ3

	property p_nom_en;
		@(posedge clock) disable iff (!arst_n)
		cfg_wr && wmask[mlfc_pkg::NOM_EN_BIT]
		|=> nomotor_lock_enable == $past(rif.wr_data[mlfc_pkg::NOM_EN_BIT]);
	endproperty
	a_nom_en: assert property (p_nom_en) else $error("no-motor enable wrong"); // RQ4

	property p_ovs_thr;
		@(posedge clock) disable iff (!arst_n)
		cfg_wr && rif.wr_strb == mlfc_pkg::STRB_ALL
		|=> overspeed_threshold_code ==
		$past(rif.wr_data[mlfc_pkg::OVS_THR_LSB +: mlfc_pkg::THR_W]);
	endproperty
	a_ovs_thr: assert property (p_ovs_thr) else $error("overspeed threshold wrong"); // RQ5

	property p_bemf_thr;
		@(posedge clock) disable iff (!arst_n)
		cfg_wr && rif.wr_strb == mlfc_pkg::STRB_ALL
		|=> backemf_threshold_code ==
		$past(rif.wr_data[mlfc_pkg::BEMF_THR_LSB +: mlfc_pkg::THR_W]);
	endproperty
	a_bemf_thr: assert property (p_bemf_thr) else $error("back-emf threshold wrong"); // RQ6

	property p_nom_thr;
		@(posedge clock) disable iff (!arst_n)
		cfg_wr && rif.wr_strb == mlfc_pkg::STRB_ALL
		|=> nomotor_current_threshold_code ==
		$past(rif.wr_data[mlfc_pkg::NOM_THR_LSB +: mlfc_pkg::THR_W]);
	endproperty
	a_nom_thr: assert property (p_nom_thr) else $error("no-motor threshold wrong"); // RQ7

	property p_fault_gate;
		@(posedge clock) disable iff (!arst_n)
		!overspeed_lock_enable |=> !overspeed_lock_fault;
	endproperty
	a_fault_gate: assert property (p_fault_gate) else $error("fault while disabled"); // RQ8

	property p_fault_pass;
		@(posedge clock) disable iff (!arst_n)
		nomotor_lock_enable && nomotor_detect |=> nomotor_lock_fault ##0
		stat_q[mlfc_pkg::EV_NOM];
	endproperty
	a_fault_pass: assert property (p_fault_pass) else $error("enabled fault dropped"); // RQ8

	property p_irq_level;
		@(posedge clock) disable iff (!arst_n)
		irq == |(stat_q & mask_q);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("interrupt level wrong");

	// the other two detectors are gated the same way
	property p_bemf_gate;
		@(posedge clock) disable iff (!arst_n)
		!backemf_lock_enable |=> !backemf_lock_fault;
	endproperty
	a_bemf_gate: assert property (p_bemf_gate) else $error("back-emf fault leaked"); // RQ8

	property p_nom_gate;
		@(posedge clock) disable iff (!arst_n)
		!nomotor_lock_enable |=> !nomotor_lock_fault;
	endproperty
	a_nom_gate: assert property (p_nom_gate) else $error("no-motor fault leaked"); // RQ8

	// write-one-to-clear empties a bit whose event has gone
	property p_stat_clear;
		@(posedge clock) disable iff (!arst_n)
		clr_vec[mlfc_pkg::EV_OVS] && !fault_d[mlfc_pkg::EV_OVS]
		|=> !stat_q[mlfc_pkg::EV_OVS];
	endproperty
	a_stat_clear: assert property (p_stat_clear) else $error("status bit not cleared");

	// an event always lands, even in the cycle it is being cleared
	property p_stat_set;
		@(posedge clock) disable iff (!arst_n)
		fault_d[mlfc_pkg::EV_NOM] |=> stat_q[mlfc_pkg::EV_NOM];
	endproperty
	a_stat_set: assert property (p_stat_set) else $error("no-motor event lost"); // RQ8

	// the word only moves on a config write
	property p_cfg_hold;
		@(posedge clock) disable iff (!arst_n)
		!cfg_wr |=> $stable(cfg_q);
	endproperty
	a_cfg_hold: assert property (p_cfg_hold) else $error("config changed unwritten"); // RQ1

	// an unmapped write leaves the config and mask registers alone
	property p_bad_write;
		@(posedge clock) disable iff (!arst_n)
		rif.wr_en && rif.wr_err |=> $stable(cfg_q) && $stable(mask_q);
	endproperty
	a_bad_write: assert property (p_bad_write) else $error("unmapped write had effect");

	c_cfg_write: cover property (@(posedge clock) disable iff (!arst_n) cfg_wr);
	c_fault: cover property (@(posedge clock) disable iff (!arst_n) backemf_lock_fault);
	c_irq: cover property (@(posedge clock) disable iff (!arst_n) irq ##1 stat_wr);
	c_partial: cover property (@(posedge clock) disable iff (!arst_n)
		cfg_wr && rif.wr_strb != mlfc_pkg::STRB_ALL);
	c_clear: cover property (@(posedge clock) disable iff (!arst_n) stat_wr && |stat_q);
endmodule : mlfc_top

// ===== mlfc_pkg.sv
// Purpose: shared constants for the motor lock fault configuration block
// Assumes: 32-bit register words, one aligned word per register index
// Notes: byte address of a register is four times its index
package mlfc_pkg;
	// bus geometry
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned STRB_W = 4;
	// register indices; byte address = index * 4
	localparam logic [7:0] CFG_IDX = 8'h92;
	localparam logic [7:0] STAT_IDX = 8'h94;
	localparam logic [7:0] MASK_IDX = 8'h96;
	// reset values
	localparam logic [31:0] CFG_RST = 32'h0000_0000;
	localparam logic [2:0] EV_RST = 3'h0;
	// field positions in the lock fault configuration word
	localparam int unsigned OVS_EN_BIT = 30;
	localparam int unsigned BEMF_EN_BIT = 29;
	localparam int unsigned NOM_EN_BIT = 28;
	localparam int unsigned OVS_THR_LSB = 25;
	localparam int unsigned BEMF_THR_LSB = 22;
	localparam int unsigned NOM_THR_LSB = 19;
	localparam int unsigned THR_W = 3;
	// event bits in status and mask
	localparam int unsigned EV_OVS = 0;
	localparam int unsigned EV_BEMF = 1;
	localparam int unsigned EV_NOM = 2;
	localparam int unsigned EV_W = 3;
	// axi response codes and the all-lanes write strobe
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [STRB_W-1:0] STRB_ALL = 4'hf;

	// byte address of a register index
	function automatic logic [ADDR_W-1:0] idx_to_addr(input logic [7:0] idx);
		return {2'h0, idx, 2'h0};
	endfunction : idx_to_addr
endpackage : mlfc_pkg

// ===== mlfc_reg_if.sv
// Purpose: internal register access carrier between bus slave and register bank
// Assumes: single clock, write and read strobes are one-cycle pulses
// Notes: read data is combinational from the bank, sampled by the slave
`timescale 1ns/10ps
interface mlfc_reg_if;
	logic wr_en; // one-cycle write pulse
	logic [mlfc_pkg::ADDR_W-1:0] wr_addr;
	logic [mlfc_pkg::DATA_W-1:0] wr_data;
	logic [mlfc_pkg::STRB_W-1:0] wr_strb;
	logic wr_err; // address unmapped
	logic rd_en; // one-cycle read pulse
	logic [mlfc_pkg::ADDR_W-1:0] rd_addr;
	logic [mlfc_pkg::DATA_W-1:0] rd_data;
	logic rd_err;
	// bus side issues requests
	modport bus (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		input wr_err, rd_data, rd_err);
	// bank side answers
	modport bank (input wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
		output wr_err, rd_data, rd_err);
endinterface : mlfc_reg_if

// ===== mlfc_axil_slave.sv
// Purpose: axi4-lite slave turning bus transfers into register strobes
// Assumes: one write and one read outstanding at most
// Notes: aw and w taken in either order; response one cycle after both held
`timescale 1ns/10ps
module mlfc_axil_slave (
	input wire logic clock,
	input wire logic arst_n,
	input wire logic [mlfc_pkg::ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [mlfc_pkg::DATA_W-1:0] s_axi_wdata,
	input wire logic [mlfc_pkg::STRB_W-1:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [mlfc_pkg::ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [mlfc_pkg::DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	mlfc_reg_if.bus rif
);
	logic aw_hold_q, aw_hold_d; // write address captured
	logic w_hold_q, w_hold_d; // write data captured
	logic [mlfc_pkg::ADDR_W-1:0] awaddr_q, awaddr_d;
	logic [mlfc_pkg::DATA_W-1:0] wdata_q, wdata_d;
	logic [mlfc_pkg::STRB_W-1:0] wstrb_q, wstrb_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic ar_hold_q, ar_hold_d; // read address captured
	logic [mlfc_pkg::ADDR_W-1:0] araddr_q, araddr_d;
	logic rvalid_q, rvalid_d;
	logic [1:0] rresp_q, rresp_d;
	logic [mlfc_pkg::DATA_W-1:0] rdata_q, rdata_d;

	// ready only while the capture slot is free, so nothing is overwritten
	assign s_axi_awready = !aw_hold_q && !bvalid_q;
	assign s_axi_wready = !w_hold_q && !bvalid_q;
	assign s_axi_arready = !ar_hold_q && !rvalid_q;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;
	// strobes toward the bank
	assign rif.wr_en = aw_hold_q && w_hold_q && !bvalid_q;
	assign rif.wr_addr = awaddr_q;
	assign rif.wr_data = wdata_q;
	assign rif.wr_strb = wstrb_q;
	assign rif.rd_en = ar_hold_q && !rvalid_q;
	assign rif.rd_addr = araddr_q;

	// next state of both channels
	always_comb begin
		aw_hold_d = aw_hold_q;
		w_hold_d = w_hold_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		ar_hold_d = ar_hold_q;
		araddr_d = araddr_q;
		rvalid_d = rvalid_q;
		rresp_d = rresp_q;
		rdata_d = rdata_q;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_hold_d = 1'b1;
			awaddr_d = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_hold_d = 1'b1;
			wdata_d = s_axi_wdata;
			wstrb_d = s_axi_wstrb;
		end
		// both halves present: write lands, response next cycle
		if (rif.wr_en) begin
			aw_hold_d = 1'b0;
			w_hold_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = rif.wr_err ? mlfc_pkg::RESP_SLVERR : mlfc_pkg::RESP_OKAY;
		end else if (bvalid_q && s_axi_bready) begin
			bvalid_d = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			ar_hold_d = 1'b1;
			araddr_d = s_axi_araddr;
		end
		// read data sampled into a flop, stable while rvalid stands
		if (rif.rd_en) begin
			ar_hold_d = 1'b0;
			rvalid_d = 1'b1;
			rdata_d = rif.rd_data;
			rresp_d = rif.rd_err ? mlfc_pkg::RESP_SLVERR : mlfc_pkg::RESP_OKAY;
		end else if (rvalid_q && s_axi_rready) begin
			rvalid_d = 1'b0;
		end
	end

	// channel registers
	always_ff @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= '0;
			wdata_q <= '0;
			wstrb_q <= '0;
			bvalid_q <= 1'b0;
			bresp_q <= mlfc_pkg::RESP_OKAY;
			ar_hold_q <= 1'b0;
			araddr_q <= '0;
			rvalid_q <= 1'b0;
			rresp_q <= mlfc_pkg::RESP_OKAY;
			rdata_q <= '0;
		end else begin
			aw_hold_q <= aw_hold_d;
			w_hold_q <= w_hold_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			ar_hold_q <= ar_hold_d;
			araddr_q <= araddr_d;
			rvalid_q <= rvalid_d;
			rresp_q <= rresp_d;
			rdata_q <= rdata_d;
		end
	end
endmodule : mlfc_axil_slave

// ===== tb_motor_lock_fault_config.sv
// Purpose: self-checking bench for the lock fault configuration block
// Assumes: axi4-lite master, all inputs driven right after rising edges
// Notes: driver queues expected answers, a monitor checks them as they appear
`timescale 1ns/10ps
module tb_motor_lock_fault_config;
	localparam logic [11:0] A_CFG = 12'h248; // index 92h, four bytes a word
	localparam logic [11:0] A_STAT = 12'h250; // sticky event status
	localparam logic [11:0] A_MASK = 12'h258; // interrupt mask
	localparam logic [11:0] A_BAD = 12'h004; // unmapped hole
	logic clock, arst_n;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata;
	logic [3:0] wstrb;
	logic [3:0] strb = 4'hf; // byte lanes of the next write
	logic awvalid, wvalid, bready, arvalid, rready;
	logic [2:0] detect; // overspeed, back-emf, no-motor
	wire logic awready, wready, bvalid, arready, rvalid, irq;
	wire logic [1:0] bresp, rresp;
	wire logic [31:0] rdata;
	wire logic [2:0] en, fault, c_ovs, c_bemf, c_nom;
	wire logic [15:0] outs = {en, c_ovs, c_bemf, c_nom, fault, irq};
	int n_errors = 0; // mismatches
	int n_compared = 0; // comparisons made
	integer seed = 32'ha9b0ae7d; // fixed seed, repeatable run
	logic [1:0] wq[$]; // expected write responses
	logic [33:0] rq[$]; // expected {rresp, rdata}
	logic [31:0] d;
	int i, k;

	mlfc_top dut (.clock(clock), .arst_n(arst_n), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .overspeed_detect(detect[2]),
		.backemf_detect(detect[1]), .nomotor_detect(detect[0]),
		.overspeed_lock_enable(en[2]), .backemf_lock_enable(en[1]),
		.nomotor_lock_enable(en[0]), .overspeed_threshold_code(c_ovs),
		.backemf_threshold_code(c_bemf), .nomotor_current_threshold_code(c_nom),
		.overspeed_lock_fault(fault[2]), .backemf_lock_fault(fault[1]),
		.nomotor_lock_fault(fault[0]), .irq(irq));

	// free-running 125 mhz clock
	initial begin
		clock = 1'b0;
		forever #4 clock = ~clock;
	end

	// verdict in one place only
	task automatic end_of_test();
		if (n_errors == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test

	// shared compare, four-state exact
	task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp

	task automatic chk_wr(input logic [1:0] got, input logic [1:0] exp);
		cmp({32'h0, got}, {32'h0, exp});
	endtask : chk_wr

	task automatic chk_rd(input logic [33:0] got, input logic [33:0] exp);
		cmp(got, exp);
	endtask : chk_rd

	task automatic chk_out(input logic [15:0] got, input logic [15:0] exp);
		cmp({18'h0, got}, {18'h0, exp});
	endtask : chk_out

	// port image expected from a config word, faults and irq
	function automatic logic [15:0] exp_outs(input logic [31:0] c, input logic [2:0] f,
		input logic q);
		return {c[30:28], c[27:25], c[24:22], c[21:19], f, q};
	endfunction : exp_outs

	// let registered outputs land, then look between edges
	task automatic settle();
		repeat (2) @(posedge clock);
		@(negedge clock);
	endtask : settle

	// one write; handshakes sampled mid-cycle so no edge race
	task automatic axi_write(input logic [11:0] a, input logic [31:0] v, input logic [1:0] r);
		logic ah, wh, bh, busy;
		@(posedge clock);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= v;
		wstrb <= strb;
		wvalid <= 1'b1;
		bready <= 1'b1;
		wq.push_back(r);
		busy = 1'b1;
		while (busy) begin
			@(negedge clock);
			ah = awvalid & awready;
			wh = wvalid & wready;
			bh = bvalid & bready;
			@(posedge clock);
			if (ah) awvalid <= 1'b0;
			if (wh) wvalid <= 1'b0;
			if (bh) begin
				bready <= 1'b0;
				busy = 1'b0;
			end
		end
	endtask : axi_write

	// one read; rready held until rvalid seen
	task automatic axi_read(input logic [11:0] a, input logic [33:0] e);
		logic ah, rh, busy;
		@(posedge clock);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		rq.push_back(e);
		busy = 1'b1;
		while (busy) begin
			@(negedge clock);
			ah = arvalid & arready;
			rh = rvalid & rready;
			@(posedge clock);
			if (ah) arvalid <= 1'b0;
			if (rh) begin
				rready <= 1'b0;
				busy = 1'b0;
			end
		end
	endtask : axi_read

	// monitor: each bus answer against the oldest note
	always @(negedge clock) begin
		if (bvalid === 1'b1 && bready === 1'b1) chk_wr(bresp, wq.pop_front());
		if (rvalid === 1'b1 && rready === 1'b1) chk_rd({rresp, rdata}, rq.pop_front());
	end

	// watchdog: the whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clock);
		n_errors++;
		end_of_test();
	end

	// main sequence
	initial begin
		arst_n = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 12'h000;
		araddr = 12'h000;
		wdata = 32'h0000_0000;
		wstrb = 4'h0;
		detect = 3'h0;
		repeat (20) @(posedge clock);
		arst_n <= 1'b1;
		@(negedge clock);
		// reset image
		chk_out(outs, 16'h0000);
		axi_read(A_CFG, 34'h0);
		axi_read(A_STAT, 34'h0);
		axi_read(A_MASK, 34'h0);
		// every code in each field, random enables and spare bits
		for (i = 0; i < 8; i++) begin
			d = $random(seed);
			d[27:19] = {i[2:0], ~i[2:0], i[2:0] ^ 3'h5};
			axi_write(A_CFG, d, 2'h0);
			axi_read(A_CFG, {2'h0, d});
			settle();
			chk_out(outs, exp_outs(d, 3'h0, 1'b0));
		end
		// unmapped access: error, no side effect
		axi_write(A_BAD, 32'hffff_ffff, 2'h2);
		axi_read(A_BAD, {2'h2, 32'h0});
		axi_read(A_CFG, {2'h0, d});
		// top byte lane only: the rest of the word keeps its value
		strb = 4'h8;
		axi_write(A_CFG, 32'hffff_ffff, 2'h0);
		strb = 4'hf;
		d[31:24] = 8'hff;
		axi_read(A_CFG, {2'h0, d});
		settle();
		chk_out(outs, exp_outs(d, 3'h0, 1'b0));
		// all detectors firing while disabled, top thresholds
		d = 32'h0ff8_0000;
		axi_write(A_CFG, d, 2'h0);
		axi_write(A_MASK, 32'h0000_0007, 2'h0);
		@(posedge clock);
		detect <= 3'h7;
		settle();
		chk_out(outs, exp_outs(d, 3'h0, 1'b0));
		axi_read(A_STAT, 34'h0);
		// enable one detector at a time, then clear its status
		for (k = 0; k < 3; k++) begin
			axi_write(A_CFG, d | (32'h4000_0000 >> k), 2'h0);
			settle();
			chk_out(outs, exp_outs(d | (32'h4000_0000 >> k), 3'h4 >> k, 1'b1));
			axi_read(A_STAT, {2'h0, 32'h1 << k});
			axi_write(A_CFG, d, 2'h0);
			axi_write(A_STAT, 32'h0000_0007, 2'h0);
			axi_read(A_STAT, 34'h0);
			settle();
			chk_out(outs, exp_outs(d, 3'h0, 1'b0));
		end
		// masked event keeps irq low until unmasked
		axi_write(A_MASK, 32'h0000_0003, 2'h0);
		axi_write(A_CFG, d | 32'h1000_0000, 2'h0);
		settle();
		chk_out(outs, exp_outs(d | 32'h1000_0000, 3'h1, 1'b0));
		axi_read(A_MASK, {2'h0, 32'h3});
		axi_write(A_MASK, 32'h0000_0007, 2'h0);
		settle();
		chk_out(outs, exp_outs(d | 32'h1000_0000, 3'h1, 1'b1));
		end_of_test();
	end
endmodule : tb_motor_lock_fault_config
